// ===== src/pmac_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmac_regs.svh"
module pmac_top
  import pmac_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic BUS_BYTE,
  output logic [15:0] BUS_RDATA,
  output logic BUS_RVALID,
  output logic RESULT_PENDING
);

  pmac_if calc ();

  // held operands, mode and result words
  logic [15:0] op1_r;
  logic [15:0] op2_r;
  pmac_mode_t mode_r;
  logic [15:0] res_lo_r;
  logic [15:0] res_hi_r;
  logic [15:0] sum_extension_r;
  logic start_r;
  logic [1:0] pend_cnt_r;
  logic [1:0] pend_cnt_nxt;

  // decoded accesses
  logic [15:0] wr_value;
  logic wr_op1;
  logic wr_op2;
  logic wr_lo;
  logic wr_hi;
  pmac_mode_t addr_mode;
  logic [15:0] rd_value;
  logic rd_hit;

  // byte writes take the low byte and clear the upper byte
  always_comb begin
    wr_value = BUS_WDATA;
    if (BUS_BYTE) begin
      wr_value = {`PMAC_BYTE_UPPER, BUS_WDATA[`PMAC_BYTE_MSB:0]}; // RL19
    end
  end

  // address decode for the four first operand aliases
  always_comb begin
    wr_op1 = 1'b0;
    addr_mode = mode_r;
    case (BUS_ADDR)
      `PMAC_ADDR_OP1_UMUL: begin
        wr_op1 = BUS_WR; // RL2
        addr_mode = PMAC_UMUL;
      end
      `PMAC_ADDR_OP1_SMUL: begin
        wr_op1 = BUS_WR; // RL2
        addr_mode = PMAC_SMUL;
      end
      `PMAC_ADDR_OP1_UACC: begin
        wr_op1 = BUS_WR; // RL2
        addr_mode = PMAC_UACC;
      end
      `PMAC_ADDR_OP1_SACC: begin
        wr_op1 = BUS_WR; // RL2
        addr_mode = PMAC_SACC;
      end
      default: begin
        wr_op1 = 1'b0;
        addr_mode = mode_r;
      end
    endcase
  end

  // write strobes for the remaining writable words
  assign wr_op2 = BUS_WR && (BUS_ADDR == `PMAC_ADDR_OP2);
  assign wr_lo = BUS_WR && (BUS_ADDR == `PMAC_ADDR_RES_LO);
  assign wr_hi = BUS_WR && (BUS_ADDR == `PMAC_ADDR_RES_HI);

  // first operand and mode: stored on write, kept until the next one
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      op1_r <= `PMAC_WORD_RESET;
      mode_r <= PMAC_UMUL;
    end else if (wr_op1) begin
      op1_r <= wr_value; // RL1
      mode_r <= addr_mode; // RL5
    end
  end

  // second operand: stored on write
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      op2_r <= `PMAC_WORD_RESET;
    end else if (wr_op2) begin
      op2_r <= wr_value;
    end
  end

  // only a second operand write launches the datapath
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr_op2; // RL3
    end
  end

  // operands go to the datapath the cycle after the launching write
  assign calc.start = start_r;
  assign calc.mode = mode_r;
  assign calc.op1 = op1_r;
  assign calc.op2 = op2_r;
  assign calc.acc = {res_hi_r, res_lo_r}; // RL18

  pmac_arith u_arith (
    .clk(CLOCK),
    .rst(RESET),
    .req(calc.unit)
  );

  // low result word: software write, overridden by a finishing operation
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      res_lo_r <= `PMAC_WORD_RESET;
    end else if (calc.done) begin
      res_lo_r <= calc.res_lo; // RL6
    end else if (wr_lo) begin
      res_lo_r <= wr_value; // RL17
    end
  end

  // high result word: same precedence as the low word
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      res_hi_r <= `PMAC_WORD_RESET;
    end else if (calc.done) begin
      res_hi_r <= calc.res_hi; // RL7
    end else if (wr_hi) begin
      res_hi_r <= wr_value; // RL17
    end
  end

  // sum extension changes only when an operation finishes
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      sum_extension_r <= `PMAC_WORD_RESET;
    end else if (calc.done) begin
      sum_extension_r <= calc.sum_extension; // RL17
    end
  end

  // pending window: counts the result latency after each launch
  always_comb begin
    pend_cnt_nxt = pend_cnt_r;
    if (wr_op2) begin
      pend_cnt_nxt = `PMAC_RESULT_CYCLES; // RL4
    end else if (pend_cnt_r != `PMAC_CNT_ZERO) begin
      pend_cnt_nxt = pend_cnt_r - `PMAC_CNT_ONE;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      pend_cnt_r <= `PMAC_CNT_ZERO;
      RESULT_PENDING <= 1'b0;
    end else begin
      pend_cnt_r <= pend_cnt_nxt;
      RESULT_PENDING <= (pend_cnt_nxt != `PMAC_CNT_ZERO); // RL4
    end
  end

  // read multiplexer; every first operand alias returns the one operand
  always_comb begin
    rd_hit = 1'b1;
    rd_value = `PMAC_UNMAPPED_DATA;
    case (BUS_ADDR)
      `PMAC_ADDR_OP1_UMUL: rd_value = op1_r;
      `PMAC_ADDR_OP1_SMUL: rd_value = op1_r;
      `PMAC_ADDR_OP1_UACC: rd_value = op1_r;
      `PMAC_ADDR_OP1_SACC: rd_value = op1_r;
      `PMAC_ADDR_OP2: rd_value = op2_r;
      `PMAC_ADDR_RES_LO: rd_value = res_lo_r;
      `PMAC_ADDR_RES_HI: rd_value = res_hi_r;
      `PMAC_ADDR_SUM_EXTENSION: rd_value = sum_extension_r; // RL17
      default: begin
        rd_hit = 1'b0;
        rd_value = `PMAC_UNMAPPED_DATA;
      end
    endcase
    if (BUS_BYTE) begin
      rd_value = {`PMAC_BYTE_UPPER, rd_value[`PMAC_BYTE_MSB:0]};
    end
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      BUS_RDATA <= `PMAC_UNMAPPED_DATA;
      BUS_RVALID <= 1'b0;
    end else begin
      BUS_RVALID <= BUS_RD;
      if (BUS_RD && rd_hit) begin
        BUS_RDATA <= rd_value;
      end else if (BUS_RD) begin
        BUS_RDATA <= `PMAC_UNMAPPED_DATA;
      end
    end
  end

endmodule
`default_nettype wire

// ===== common/pmac_regs.svh
// Summary of operation
// RL1: writing the first operand stores it and its mode only; nothing starts.
// RL2: first operand sits at 0130h, 0132h, 0134h, 0136h, each selecting a mode.
// RL3: writing the second operand at 0138h starts the last selected operation.
// RL4: results are valid no later than three clocks after the second operand write.
// RL5: first operand and mode stay held, so repeated second operand writes repeat.
// RL6: low result word always carries result bits 15 to 0.
// RL7: unsigned modes put result bits 31 to 16 in the high result word.
// RL8: signed multiply gives a two's complement product, sign in the top bit.
// RL9: signed accumulate keeps upper sixteen bits of a two's complement 32-bit sum.
// RL10: after unsigned multiply the sum extension reads zero.
// RL11: signed modes put the sign extension of the result in sum extension.
// RL12: unsigned accumulate puts the carry out of the 32-bit add in sum extension.
// RL13: signed accumulate has no overflow detection; the 32-bit sum simply wraps.
// RL14: after signed wrap, sum extension follows the sign of the wrapped result.
// RL15: software reading results indirectly leaves one instruction after the write.
// RL16: software keeps interrupts off between operand writes or avoids the unit in handlers.
// RL17: sum extension is read only; operands and both result words are read/write.
// RL18: accumulate modes add the product to the current high and low result words.
// RL19: a byte write loads the low eight bits and clears the upper eight.
`ifndef PMAC_REGS_SVH
`define PMAC_REGS_SVH

// register byte addresses
`define PMAC_ADDR_OP1_UMUL 16'h0130
`define PMAC_ADDR_OP1_SMUL 16'h0132
`define PMAC_ADDR_OP1_UACC 16'h0134
`define PMAC_ADDR_OP1_SACC 16'h0136
`define PMAC_ADDR_OP2 16'h0138
`define PMAC_ADDR_RES_LO 16'h013A
`define PMAC_ADDR_RES_HI 16'h013C
`define PMAC_ADDR_SUM_EXTENSION 16'h013E

// reset values and fixed answers
`define PMAC_WORD_RESET 16'h0000
`define PMAC_ACC_RESET 32'h0000_0000
`define PMAC_UNMAPPED_DATA 16'h0000
`define PMAC_SUM_EXTENSION_ZERO 16'h0000
`define PMAC_SUM_EXTENSION_ONES 16'hFFFF
`define PMAC_SUM_EXTENSION_CARRY 16'h0001

// field layout
`define PMAC_BYTE_MSB 7
`define PMAC_WORD_MSB 15
`define PMAC_RES_MSB 31
`define PMAC_HI_LSB 16
`define PMAC_CARRY_BIT 32
`define PMAC_BYTE_UPPER 8'h00

// result latency ceiling in clock cycles
`define PMAC_RESULT_CYCLES 2'h3
`define PMAC_CNT_ZERO 2'h0
`define PMAC_CNT_ONE 2'h1

`endif

// ===== common/pmac_pkg.sv
package pmac_pkg;

  // operation selected by the first operand address
  typedef enum logic [1:0] {
    PMAC_UMUL,
    PMAC_SMUL,
    PMAC_UACC,
    PMAC_SACC
  } pmac_mode_t;

endpackage

// ===== common/pmac_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pmac_if;
  import pmac_pkg::*;

  // operation request from the register side
  logic start;
  pmac_mode_t mode;
  logic [15:0] op1;
  logic [15:0] op2;
  logic [31:0] acc;
  // finished result back to the register side
  logic done;
  logic [15:0] res_lo;
  logic [15:0] res_hi;
  logic [15:0] sum_extension;

  modport core (
    output start, mode, op1, op2, acc,
    input done, res_lo, res_hi, sum_extension
  );
  modport unit (
    input start, mode, op1, op2, acc,
    output done, res_lo, res_hi, sum_extension
  );
endinterface
`default_nettype wire

// ===== src/pmac_arith.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmac_regs.svh"
module pmac_arith
  import pmac_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pmac_if.unit req
);

  logic [33:0] prod_full;
  logic [31:0] prod_r;
  pmac_mode_t mode_r;
  logic valid_r;
  logic [32:0] sum_u;
  logic [31:0] total;
  logic [15:0] ext;

  // operands widen by sign only in the signed modes
  always_comb begin
    logic sgn;
    sgn = (req.mode == PMAC_SMUL) || (req.mode == PMAC_SACC);
    prod_full = $signed({sgn & req.op1[`PMAC_WORD_MSB], req.op1}) *
                $signed({sgn & req.op2[`PMAC_WORD_MSB], req.op2}); // RL8
  end

  // first stage registers the product
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prod_r <= `PMAC_ACC_RESET;
      mode_r <= PMAC_UMUL;
      valid_r <= 1'b0;
    end else begin
      prod_r <= prod_full[`PMAC_RES_MSB:0];
      mode_r <= req.mode;
      valid_r <= req.start;
    end
  end

  // second stage adds the accumulator and forms the sum extension
  always_comb begin
    sum_u = {1'b0, req.acc} + {1'b0, prod_r}; // RL18
    total = prod_r;
    ext = `PMAC_SUM_EXTENSION_ZERO; // RL10
    case (mode_r)
      PMAC_UMUL: begin
        total = prod_r; // RL7
        ext = `PMAC_SUM_EXTENSION_ZERO; // RL10
      end
      PMAC_SMUL: begin
        total = prod_r; // RL8
        ext = prod_r[`PMAC_RES_MSB] ? `PMAC_SUM_EXTENSION_ONES : `PMAC_SUM_EXTENSION_ZERO; // RL11
      end
      PMAC_UACC: begin
        total = sum_u[`PMAC_RES_MSB:0]; // RL7
        ext = sum_u[`PMAC_CARRY_BIT] ? `PMAC_SUM_EXTENSION_CARRY : `PMAC_SUM_EXTENSION_ZERO; // RL12
      end
      PMAC_SACC: begin
        total = sum_u[`PMAC_RES_MSB:0]; // RL13
        ext = total[`PMAC_RES_MSB] ? `PMAC_SUM_EXTENSION_ONES : `PMAC_SUM_EXTENSION_ZERO; // RL14
      end
      default: begin
        total = prod_r;
        ext = `PMAC_SUM_EXTENSION_ZERO;
      end
    endcase
  end

  // results go straight out and the register side latches them on done;
  // a further stage here would let a back-to-back accumulate add a stale sum
  assign req.done = valid_r;
  assign req.res_lo = total[`PMAC_WORD_MSB:0]; // RL6
  assign req.res_hi = total[`PMAC_RES_MSB:`PMAC_HI_LSB]; // RL9
  assign req.sum_extension = ext;

endmodule
`default_nettype wire

// ===== tb/pmac_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pmac_chk
  import pmac_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [15:0] BUS_ADDR,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic BUS_BYTE,
  input wire logic [15:0] BUS_RDATA,
  input wire logic BUS_RVALID,
  input wire logic RESULT_PENDING
);
  pmac_mode_t sel_r;
  pmac_mode_t last_r;
  logic op1_w;
  logic se_rd;
  // first operand write and settled sum extension read
  assign op1_w = BUS_WR && BUS_ADDR[15:3] == 13'h0026 && !BUS_ADDR[0];
  assign se_rd = BUS_RD && !BUS_BYTE && BUS_ADDR == 16'h013E && !RESULT_PENDING;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // selected mode and mode of the last started operation
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      sel_r <= PMAC_UMUL;
      last_r <= PMAC_UMUL;
    end else begin
      if (op1_w)
        sel_r <= pmac_mode_t'(BUS_ADDR[2:1]);
      if (BUS_WR && BUS_ADDR == 16'h0138)
        last_r <= sel_r;
    end
  end
  chk_read_answer: assert property (BUS_RD |=> BUS_RVALID)
    else $error("read not answered");
  chk_valid_pulse: assert property (!BUS_RD |=> !BUS_RVALID)
    else $error("stray read valid");
  chk_rdata_hold: assert property (!BUS_RD |=> $stable(BUS_RDATA))
    else $error("read data moved");
  chk_pend_len: assert property ((BUS_WR && BUS_ADDR == 16'h0138 && !RESULT_PENDING)
    |=> RESULT_PENDING [*3] ##1 !RESULT_PENDING) else $error("bad pending");
  chk_op1_idle: assert property (op1_w && !RESULT_PENDING |=> !RESULT_PENDING)
    else $error("first operand started work");
  chk_unmapped: assert property (BUS_RD && BUS_ADDR == 16'h0140 |=> BUS_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  chk_byte_upper: assert property (BUS_RD && BUS_BYTE |=> BUS_RDATA[15:8] == 8'h00)
    else $error("byte read upper not zero");
  chk_se_umul: assert property (se_rd && last_r == PMAC_UMUL |=> BUS_RDATA == 16'h0000)
    else $error("sum extension not zero");
  chk_se_carry: assert property (se_rd && last_r == PMAC_UACC
    |=> BUS_RDATA inside {16'h0000, 16'h0001}) else $error("bad carry");
  chk_se_sign: assert property (se_rd && last_r[0]
    |=> BUS_RDATA inside {16'h0000, 16'hFFFF}) else $error("bad sign");
  cov_start: cover property (BUS_WR && BUS_ADDR == 16'h0138);
  cov_se_read: cover property (se_rd);
  cov_byte_wr: cover property (BUS_WR && BUS_BYTE);
endmodule
bind pmac_top pmac_chk u_chk (.CLOCK(CLOCK), .RESET(RESET), .BUS_ADDR(BUS_ADDR),
  .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_BYTE(BUS_BYTE), .BUS_RDATA(BUS_RDATA),
  .BUS_RVALID(BUS_RVALID), .RESULT_PENDING(RESULT_PENDING));
`default_nettype wire

// ===== tb/pmac_cpu.sv
`timescale 1ns/10ps
`default_nettype none
module pmac_cpu (
  input wire logic clk,
  output logic [15:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  output logic byte_sel,
  input wire logic [15:0] rdata
);
  // idle bus at time zero
  initial begin
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    byte_sel = 1'b0;
  end
  // one write; released lines show inverted values
  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d, input logic b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    byte_sel <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // one read; data taken the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a, input logic b, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    byte_sel <= b;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ===== tb/peripheral_multiply_accumulate_tb.sv
`timescale 1ns/10ps
`default_nettype none
module peripheral_multiply_accumulate_tb;
  import pmac_pkg::*;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  wire logic [15:0] addr;
  wire logic [15:0] wdata;
  wire logic [15:0] rdata;
  wire logic wr;
  wire logic rd;
  wire logic bsel;
  wire logic rvalid;
  wire logic pend;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] acc_m = 32'h0;
  logic [15:0] x_m = 16'h0;
  logic [15:0] se_m = 16'h0;
  logic [1:0] mode_m = 2'h0;
  // free running clock
  always #4 CLOCK = ~CLOCK;
  pmac_cpu cpu (.clk(CLOCK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .byte_sel(bsel), .rdata(rdata));
  pmac_top dut (.CLOCK(CLOCK), .RESET(RESET), .BUS_ADDR(addr), .BUS_WDATA(wdata),
    .BUS_WR(wr), .BUS_RD(rd), .BUS_BYTE(bsel), .BUS_RDATA(rdata), .BUS_RVALID(rvalid),
    .RESULT_PENDING(pend));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single-bit status compare
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read with data and answer strobe both looked at while they stand
  task automatic rdc(input logic [15:0] a, input logic b, input logic [15:0] exp);
    logic [15:0] d;
    cpu.bus_rd(a, b, d);
    cmp_bit(rvalid, 1'b1);
    cmp(d, exp);
  endtask
  // one operation; a1 of zero repeats with the held first operand
  task automatic run(input logic [15:0] a1, input logic [15:0] x, input logic [15:0] y,
    input logic bw);
    logic [15:0] ym;
    logic [31:0] p;
    logic [32:0] s;
    if (a1 != 16'h0000) begin
      mode_m = a1[2:1];
      x_m = bw ? {8'h00, x[7:0]} : x;
      cpu.bus_wr(a1, x, bw);
      rdc(16'h013A, 1'b0, acc_m[15:0]);
    end
    ym = bw ? {8'h00, y[7:0]} : y;
    cpu.bus_wr(16'h0138, y, bw);
    p = {{16{x_m[15] & mode_m[0]}}, x_m} * {{16{ym[15] & mode_m[0]}}, ym};
    s = mode_m[1] ? {1'b0, acc_m} + {1'b0, p} : {1'b0, p};
    acc_m = s[31:0];
    se_m = mode_m[0] ? {16{s[31]}} : {15'h0000, s[32] & mode_m[1]};
    @(posedge CLOCK);
    cmp_bit(pend, 1'b1);
    rdc(16'h013A, 1'b0, acc_m[15:0]);
    rdc(16'h013C, 1'b0, acc_m[31:16]);
    rdc(16'h013E, 1'b0, se_m);
    cmp_bit(pend, 1'b0);
  endtask
  // preload the result words
  task automatic setres(input logic [31:0] v);
    cpu.bus_wr(16'h013A, v[15:0], 1'b0);
    cpu.bus_wr(16'h013C, v[31:16], 1'b0);
    acc_m = v;
  endtask
  // cycle ceiling
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge CLOCK);
    RESET <= 1'b0;
    rdc(16'h013E, 1'b0, 16'h0000);
    rdc(16'h0140, 1'b0, 16'h0000);
    run(16'h0130, 16'h1234, 16'h5678, 1'b0);
    run(16'h0132, 16'hFFFE, 16'h0003, 1'b0);
    rdc(16'h0130, 1'b0, 16'hFFFE);
    run(16'h0134, 16'hFFFF, 16'hFFFF, 1'b0);
    run(16'h0000, 16'h0000, 16'h0002, 1'b0);
    setres(32'h7FFF_FFFF);
    run(16'h0136, 16'h7FFF, 16'h7FFF, 1'b0);
    setres(32'h8000_0000);
    run(16'h0136, 16'h8000, 16'h7FFF, 1'b0);
    run(16'h0130, 16'hAB12, 16'h5634, 1'b1);
    cpu.bus_wr(16'h013E, 16'h1234, 1'b0);
    rdc(16'h013E, 1'b0, se_m);
    rdc(16'h0138, 1'b1, 16'h0034);
    // reset in mid-run clears the result words, then accumulate starts from zero
    @(posedge CLOCK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RESET <= 1'b0;
    acc_m = 32'h0;
    rdc(16'h013A, 1'b0, 16'h0000);
    rdc(16'h013E, 1'b0, 16'h0000);
    run(16'h0134, 16'h0003, 16'h0005, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
